// ==== aif_pkg.sv ====
// Function
// - Flush filter when error exceeds reset window
// - Window count is 360/32768 degree per step
// - Zero window disables threshold flush entirely
// - Boot loads window bits 23:20, pads rest
// - Coefficient bits 14:0 unsigned magnitude, n/16384
// - Coefficient bit 15 negates the magnitude
// - All numerators scaled by two to minus exponent
// - Boot loads exponent bits 20:16, clears 23:21
// - Count sets harmonic components used per angle
// - Count used only while harmonic correction enabled
// - Boot caps count at 11, software up to 15
// - Count in 19:16, bits 23:20 read zero
// - Stored count 10/11 at boot reuses stored words as coefficients
// - Filter used only while smoothing enable set
package aif_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          ANGLE_W         = 16;
  localparam int          HWORDS          = 6;
  localparam int          HWORD_W         = 16;
  // Printed offsets are word indices; byte address is four times that
  localparam logic [7:0]  IDX_WINDOW_COEF1 = 8'h07;
  localparam logic [7:0]  IDX_SCALE_COEF2  = 8'h08;
  localparam logic [7:0]  IDX_COUNT_COEF3  = 8'h09;
  localparam logic [ADDR_W-1:0] ADDR_WINDOW_COEF1 = 8'h1C;
  localparam logic [ADDR_W-1:0] ADDR_SCALE_COEF2  = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_COUNT_COEF3  = 8'h24;
  localparam int          HI_LSB          = 16;
  localparam int          COEF_SIGN       = 15;
  localparam int          COEF_FRAC       = 14;
  localparam logic [8:0]  COEF_FRAC_SH    = 9'h00E;
  localparam logic [15:0] WINDOW_RESET    = 16'h0000;
  localparam logic [7:0]  SCALE_RESET     = 8'h00;
  localparam logic [3:0]  COUNT_RESET     = 4'h0;
  localparam logic [15:0] COEF_RESET      = 16'h0000;
  localparam logic [3:0]  COUNT_BOOT_CAP  = 4'hB;
  localparam logic [3:0]  COUNT_REUSE_LO  = 4'hA;
  localparam logic [3:0]  COUNT_REUSE_HI  = 4'hB;
  typedef enum logic [1:0] {
    AIF_BOOT = 2'b01,
    AIF_RUN  = 2'b10
  } aif_phase_t;
endpackage : aif_pkg

// ==== aif_filter_core.sv ====
`timescale 1ns/10ps
`default_nettype none
// Boot-loaded, software-writable field; the boot load wins over a write
module aif_field_reg #(
  parameter int           W     = 16,
  parameter logic [W-1:0] RESET = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         boot,
  input  wire logic [W-1:0] boot_value,
  input  wire logic         wr_en,
  input  wire logic [W-1:0] wr_value,
  output var  logic [W-1:0] value
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      value <= RESET;
    end else if (ce && boot) begin
      value <= boot_value;
    end else if (ce && wr_en) begin
      value <= wr_value;
    end
  end
endmodule : aif_field_reg

module aif_filter_core (
  input  wire logic                                  clk,
  input  wire logic                                  rstn,
  input  wire logic                                  ce,
  input  wire logic [aif_pkg::ADDR_W-1:0]            addr,
  input  wire logic [aif_pkg::DATA_W-1:0]            wdata,
  input  wire logic                                  wr,
  input  wire logic                                  rd,
  output var  logic [aif_pkg::DATA_W-1:0]            rdata,
  input  wire logic [3:0]                            stored_reset_window,
  input  wire logic [4:0]                            stored_scale_exponent,
  input  wire logic [15:0]                           stored_coef_first,
  input  wire logic [15:0]                           stored_coef_second,
  input  wire logic [15:0]                           stored_coef_third,
  input  wire logic [3:0]                            stored_component_count,
  input  wire logic [aif_pkg::HWORDS*aif_pkg::HWORD_W-1:0] stored_harmonic_words,
  input  wire logic                                  angle_smoothing_enable,
  input  wire logic                                  harmonic_correction_enable,
  input  wire logic [15:0]                           filter_den_second,
  input  wire logic [15:0]                           filter_den_third,
  input  wire logic [aif_pkg::ANGLE_W-1:0]           angle_in,
  input  wire logic                                  angle_in_valid,
  output var  logic [aif_pkg::ANGLE_W-1:0]           angle_out,
  output var  logic                                  angle_out_valid,
  output var  logic                                  filter_flush,
  output var  logic [3:0]                            harmonic_count_used,
  output var  logic [aif_pkg::HWORDS*aif_pkg::HWORD_W-1:0] harmonic_coef_extra,
  output var  logic                                  displaced_defaults
);
  import aif_pkg::*;

  logic       rst_s1;
  logic       rst_s2;
  aif_phase_t phase;
  aif_phase_t next_phase;

  logic [15:0] filter_reset_window;
  logic [15:0] filter_coef_first;
  logic [7:0]  numerator_scale_exponent;
  logic [15:0] filter_coef_second;
  logic [3:0]  harmonic_component_count;
  logic [15:0] filter_coef_third;

  logic signed [16:0] x1;
  logic signed [16:0] x2;
  logic signed [16:0] y1;
  logic signed [16:0] y2;

  // Reset release through two flops; async assert only
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  wire rst_n_int = rst_s2;
  wire booting   = (phase == AIF_BOOT);

  always_comb begin
    next_phase = phase;
    unique case (phase)
      AIF_BOOT: next_phase = AIF_RUN;
      AIF_RUN:  next_phase = AIF_RUN;
      default:  next_phase = AIF_BOOT;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      phase <= AIF_BOOT;
    end else if (ce) begin
      phase <= next_phase;
    end
  end

  // Boot images of the stored fields, padded into the volatile layout
  wire [15:0] boot_window = {8'h00, stored_reset_window, 4'h0};
  wire [7:0]  boot_scale  = {3'b000, stored_scale_exponent};
  wire [3:0]  boot_count  = (stored_component_count > COUNT_BOOT_CAP) ?
                            COUNT_BOOT_CAP : stored_component_count;
  wire        boot_reuse  = (stored_component_count == COUNT_REUSE_LO) ||
                            (stored_component_count == COUNT_REUSE_HI);

  // Register decode; writes during the boot cycle are ignored
  wire run_wr  = wr && !booting;
  wire wr_sel1 = run_wr && (addr == ADDR_WINDOW_COEF1);
  wire wr_sel2 = run_wr && (addr == ADDR_SCALE_COEF2);
  wire wr_sel3 = run_wr && (addr == ADDR_COUNT_COEF3);

  // Field slices of a write word; window takes all 16 bits, scale takes all of bits 23:16, count padding is never stored
  wire [15:0] wr_window = wdata[HI_LSB+:16];
  wire [15:0] wr_coef   = wdata[HI_LSB-1:0];
  wire [7:0]  wr_scale  = wdata[HI_LSB+:8];
  wire [3:0]  wr_count  = wdata[HI_LSB+:4];

  // One register per field, all sharing boot and write timing
  aif_field_reg #(.W(16), .RESET(WINDOW_RESET)) u_reg_window (
    .clk        (clk),
    .rst_n      (rst_n_int),
    .ce         (ce),
    .boot       (booting),
    .boot_value (boot_window),
    .wr_en      (wr_sel1),
    .wr_value   (wr_window),
    .value      (filter_reset_window)
  );

  aif_field_reg #(.W(16), .RESET(COEF_RESET)) u_reg_coef_first (
    .clk        (clk),
    .rst_n      (rst_n_int),
    .ce         (ce),
    .boot       (booting),
    .boot_value (stored_coef_first),
    .wr_en      (wr_sel1),
    .wr_value   (wr_coef),
    .value      (filter_coef_first)
  );

  aif_field_reg #(.W(8), .RESET(SCALE_RESET)) u_reg_scale (
    .clk        (clk),
    .rst_n      (rst_n_int),
    .ce         (ce),
    .boot       (booting),
    .boot_value (boot_scale),
    .wr_en      (wr_sel2),
    .wr_value   (wr_scale),
    .value      (numerator_scale_exponent)
  );

  aif_field_reg #(.W(16), .RESET(COEF_RESET)) u_reg_coef_second (
    .clk        (clk),
    .rst_n      (rst_n_int),
    .ce         (ce),
    .boot       (booting),
    .boot_value (stored_coef_second),
    .wr_en      (wr_sel2),
    .wr_value   (wr_coef),
    .value      (filter_coef_second)
  );

  aif_field_reg #(.W(4), .RESET(COUNT_RESET)) u_reg_count (
    .clk        (clk),
    .rst_n      (rst_n_int),
    .ce         (ce),
    .boot       (booting),
    .boot_value (boot_count),
    .wr_en      (wr_sel3),
    .wr_value   (wr_count),
    .value      (harmonic_component_count)
  );

  aif_field_reg #(.W(16), .RESET(COEF_RESET)) u_reg_coef_third (
    .clk        (clk),
    .rst_n      (rst_n_int),
    .ce         (ce),
    .boot       (booting),
    .boot_value (stored_coef_third),
    .wr_en      (wr_sel3),
    .wr_value   (wr_coef),
    .value      (filter_coef_third)
  );

  // Reused stored words become dedicated coefficients at boot only
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      harmonic_coef_extra <= '0;
      displaced_defaults  <= 1'b0;
    end else if (ce && booting) begin
      harmonic_coef_extra <= boot_reuse ? stored_harmonic_words : '0;
      displaced_defaults  <= boot_reuse;
    end
  end

  // Count is forwarded only while harmonic correction is on
  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      harmonic_count_used <= COUNT_RESET;
    end else if (ce) begin
      harmonic_count_used <= harmonic_correction_enable ?
                             harmonic_component_count : COUNT_RESET;
    end
  end

  // Read mux; upper padding of the count reads as zero
  wire        rd_sel1  = (addr == ADDR_WINDOW_COEF1);
  wire        rd_sel2  = (addr == ADDR_SCALE_COEF2);
  wire        rd_sel3  = (addr == ADDR_COUNT_COEF3);
  wire [31:0] rd_word1 = {filter_reset_window, filter_coef_first};
  wire [31:0] rd_word2 = {8'h00, numerator_scale_exponent, filter_coef_second};
  wire [31:0] rd_word3 = {12'h000, harmonic_component_count,
                          filter_coef_third};
  // Unmapped addresses select nothing and read as zero
  wire [31:0] rd_mux   = ({32{rd_sel1}} & rd_word1) |
                         ({32{rd_sel2}} & rd_word2) |
                         ({32{rd_sel3}} & rd_word3);

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      rdata <= 32'h0000_0000;
    end else if (ce) begin
      rdata <= rd ? rd_mux : 32'h0000_0000;
    end
  end

  // Sign-magnitude to two's complement; magnitude is negated when bit 15 is set
  function automatic logic signed [16:0] sm_to_s(input logic [15:0] v);
    logic signed [16:0] mag;
    mag = $signed({2'b00, v[14:0]});
    sm_to_s = v[COEF_SIGN] ? -mag : mag;
  endfunction : sm_to_s

  wire signed [16:0] c1 = sm_to_s(filter_coef_first);
  wire signed [16:0] c2 = sm_to_s(filter_coef_second);
  wire signed [16:0] c3 = sm_to_s(filter_coef_third);
  wire signed [16:0] d2 = sm_to_s(filter_den_second);
  wire signed [16:0] d3 = sm_to_s(filter_den_third);
  wire signed [16:0] x0 = $signed({1'b0, angle_in});

  wire signed [33:0] p1 = x0 * c1;
  wire signed [33:0] p2 = x1 * c2;
  wire signed [33:0] p3 = x2 * c3;
  wire signed [33:0] q2 = y1 * d2;
  wire signed [33:0] q3 = y2 * d3;

  wire signed [35:0] num_sum = 36'(p1) + 36'(p2) + 36'(p3);
  wire signed [35:0] den_sum = 36'(q2) + 36'(q3);
  // Numerators carry the extra exponent; wide shifts simply go to sign
  wire        [8:0]  num_sh     = {1'b0, numerator_scale_exponent} +
                                  COEF_FRAC_SH;
  wire signed [35:0] num_scaled = num_sum >>> num_sh;
  wire signed [35:0] den_scaled = den_sum >>> COEF_FRAC_SH;
  wire signed [35:0] filt_full  = num_scaled - den_scaled;
  wire        [15:0] filt_out   = filt_full[15:0];

  // Angle error taken modulo a full turn, so wrap at 0/360 stays small
  wire [15:0] err_raw = angle_in - y1[15:0];
  wire [15:0] err_abs = err_raw[15] ? (16'h0000 - err_raw) : err_raw;
  wire        window_on = (filter_reset_window != 16'h0000);
  // A window count is 1/32768 turn, i.e. two angle steps
  wire [16:0] window_span = {filter_reset_window, 1'b0};
  wire        flush_hit = angle_smoothing_enable && window_on &&
                          ({1'b0, err_abs} > window_span);
  // Bypass also refills state so enabling later starts clean
  wire        reload    = flush_hit || !angle_smoothing_enable;
  wire        take      = ce && angle_in_valid && !booting;

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      x1 <= '0;
      x2 <= '0;
      y1 <= '0;
      y2 <= '0;
    end else if (take && reload) begin
      x1 <= x0;
      x2 <= x0;
      y1 <= x0;
      y2 <= x0;
    end else if (take) begin
      x1 <= x0;
      x2 <= x1;
      y1 <= $signed({1'b0, filt_out});
      y2 <= y1;
    end
  end

  always_ff @(posedge clk or negedge rst_n_int) begin
    if (!rst_n_int) begin
      angle_out       <= 16'h0000;
      angle_out_valid <= 1'b0;
      filter_flush    <= 1'b0;
    end else if (ce) begin
      angle_out_valid <= take;
      filter_flush    <= take && flush_hit;
      if (take) begin
        angle_out <= reload ? angle_in : filt_out;
      end
    end
  end

endmodule : aif_filter_core
`default_nettype wire

// ==== aif_filter_core_properties.sv ====
`timescale 1ns/10ps
`default_nettype none
module aif_filter_core_chk (
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         ce,
  input wire logic [aif_pkg::ADDR_W-1:0]   addr,
  input wire logic                         rd,
  input wire logic [aif_pkg::DATA_W-1:0]   rdata,
  input wire logic                         angle_smoothing_enable,
  input wire logic                         harmonic_correction_enable,
  input wire logic [aif_pkg::ANGLE_W-1:0]  angle_in,
  input wire logic                         angle_in_valid,
  input wire logic [aif_pkg::ANGLE_W-1:0]  angle_out,
  input wire logic                         angle_out_valid,
  input wire logic                         filter_flush,
  input wire logic [3:0]                   harmonic_count_used,
  input wire logic [95:0]                  harmonic_coef_extra,
  input wire logic                         displaced_defaults
);
  import aif_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle_zero: assert property (ce && !rd |=> rdata == 32'h0)
    else $error("rdata not zero after idle cycle");
  a_scale_pad_zero: assert property (
    ce && rd && addr == ADDR_SCALE_COEF2 |=> rdata[31:24] == 8'h00)
    else $error("scale register upper byte not zero");
  a_count_pad_zero: assert property (
    ce && rd && addr == ADDR_COUNT_COEF3 |=> rdata[31:20] == 12'h000)
    else $error("count register padding not zero");
  a_valid_has_cause: assert property (
    angle_out_valid |-> $past(ce && angle_in_valid))
    else $error("output valid without a sample");
  a_flush_when_smooth: assert property (
    filter_flush |-> angle_out_valid && $past(angle_smoothing_enable))
    else $error("flush outside smoothing");
  a_flush_reloads: assert property (
    filter_flush |-> angle_out == $past(angle_in))
    else $error("flush output differs from sample");
  a_bypass_passes: assert property (
    (ce && angle_in_valid && !angle_smoothing_enable) ##1 angle_out_valid
    |-> angle_out == $past(angle_in))
    else $error("bypass output differs from sample");
  a_count_gated: assert property (
    ce && !harmonic_correction_enable |=> harmonic_count_used == 4'h0)
    else $error("count used while correction disabled");
  a_extra_gated: assert property (
    !displaced_defaults |-> harmonic_coef_extra == 96'h0)
    else $error("extra coefficients without reuse");
  a_out_holds: assert property (!(ce && angle_in_valid) |=> $stable(angle_out))
    else $error("angle output moved between samples");
endmodule : aif_filter_core_chk
bind aif_filter_core aif_filter_core_chk u_chk (.clk(clk), .rstn(rstn),
  .ce(ce), .addr(addr), .rd(rd), .rdata(rdata), .angle_in(angle_in),
  .angle_smoothing_enable(angle_smoothing_enable),
  .harmonic_correction_enable(harmonic_correction_enable),
  .angle_in_valid(angle_in_valid), .angle_out(angle_out),
  .angle_out_valid(angle_out_valid), .filter_flush(filter_flush),
  .harmonic_count_used(harmonic_count_used),
  .harmonic_coef_extra(harmonic_coef_extra),
  .displaced_defaults(displaced_defaults));
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import aif_pkg::*;
  logic        clk, rstn, ce, wr, rd, smooth, hce, ang_v, out_v, flush, disp;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  s_win, s_cnt, used;
  logic [4:0]  s_exp;
  logic [15:0] s_c1, s_c2, s_c3, den2, den3, ang, out;
  logic [95:0] s_words, extra;
  int          num_errors, checks, cycles;

  aif_filter_core u_aif_filter_core (.clk(clk), .rstn(rstn), .ce(ce),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .stored_reset_window(s_win), .stored_scale_exponent(s_exp),
    .stored_coef_first(s_c1), .stored_coef_second(s_c2),
    .stored_coef_third(s_c3), .stored_component_count(s_cnt),
    .stored_harmonic_words(s_words), .angle_smoothing_enable(smooth),
    .harmonic_correction_enable(hce), .filter_den_second(den2),
    .filter_den_third(den3), .angle_in(ang), .angle_in_valid(ang_v),
    .angle_out(out), .angle_out_valid(out_v), .filter_flush(flush),
    .harmonic_count_used(used), .harmonic_coef_extra(extra),
    .displaced_defaults(disp));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  // Generous ceiling; the whole sequence needs about a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic chk(input string what, input logic [95:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk("rdata", rdata, e);
  endtask : rreg

  task automatic samp(input logic [15:0] a, e, input logic f);
    @(posedge clk);
    ang   <= a;
    ang_v <= 1'b1;
    @(posedge clk);
    ang_v <= 1'b0;
    #1;
    chk("angle_out_valid", out_v, 1'b1);
    chk("angle_out", out, e);
    chk("filter_flush", flush, f);
  endtask : samp

  task automatic do_reset(input logic [3:0] cnt);
    @(posedge clk);
    rstn  <= 1'b0;
    s_cnt <= cnt;
    repeat (16) @(posedge clk);
    rstn  <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : do_reset

  task automatic t_boot_cap;
    do_reset(4'hF);
    rreg(ADDR_WINDOW_COEF1, {16'h00A0, s_c1});
    rreg(ADDR_SCALE_COEF2, {8'h00, 8'h1F, s_c2});
    rreg(ADDR_COUNT_COEF3, {12'h000, 4'hB, s_c3});
  endtask : t_boot_cap

  task automatic t_boot_reuse;
    do_reset(4'hA);
    #1;
    chk("displaced_defaults", disp, 1'b1);
    chk("harmonic_coef_extra", extra, s_words);
    rreg(ADDR_COUNT_COEF3, {12'h000, 4'hA, s_c3});
  endtask : t_boot_reuse

  task automatic t_regs;
    wreg(ADDR_WINDOW_COEF1, 32'hFFFF_8001);
    rreg(ADDR_WINDOW_COEF1, 32'hFFFF_8001);
    wreg(ADDR_SCALE_COEF2, 32'hFFFF_FFFF);
    rreg(ADDR_SCALE_COEF2, 32'h00FF_FFFF);
    wreg(ADDR_COUNT_COEF3, 32'hFFFF_FFFF);
    rreg(ADDR_COUNT_COEF3, 32'h000F_FFFF);
    rreg(8'h28, 32'h0);
    @(posedge clk);
    hce <= 1'b1;
    repeat (3) @(posedge clk);
    chk("harmonic_count_used", used, 4'hF);
    hce <= 1'b0;
    repeat (3) @(posedge clk);
    chk("harmonic_count_used", used, 4'h0);
    @(posedge clk);
    ce    <= 1'b0;
    ang_v <= 1'b1;
    @(posedge clk);
    ce    <= 1'b1;
    ang_v <= 1'b0;
    #1;
    chk("angle_out_valid", out_v, 1'b0);
  endtask : t_regs

  task automatic t_filter;
    samp(16'h1000, 16'h1000, 1'b0);
    wreg(ADDR_WINDOW_COEF1, 32'h0008_4000);
    wreg(ADDR_SCALE_COEF2, 32'h0);
    wreg(ADDR_COUNT_COEF3, 32'h0);
    smooth <= 1'b1;
    samp(16'h1000, 16'h1000, 1'b0);
    samp(16'h1011, 16'h1011, 1'b1);
    samp(16'h1021, 16'h1021, 1'b0);
    wreg(ADDR_WINDOW_COEF1, 32'h0000_4000);
    samp(16'h9000, 16'h9000, 1'b0);
    wreg(ADDR_WINDOW_COEF1, 32'h0000_C000);
    samp(16'h0100, 16'hFF00, 1'b0);
    wreg(ADDR_WINDOW_COEF1, 32'h0000_4000);
    wreg(ADDR_SCALE_COEF2, 32'h0001_0000);
    samp(16'h0200, 16'h0100, 1'b0);
  endtask : t_filter

  initial begin
    {rstn, wr, rd, smooth, hce, ang_v, addr, wdata, ang} <= '0;
    ce      <= 1'b1;
    s_win   <= 4'hA;
    s_exp   <= 5'h1F;
    s_c1    <= 16'h8123;
    s_c2    <= 16'h7FFF;
    s_c3    <= 16'h1234;
    s_words <= 96'h1A1A_1919_1818_1717_1616_1515;
    den2    <= 16'h0000;
    den3    <= 16'h0000;
    t_boot_cap();
    t_boot_reuse();
    t_regs();
    t_filter();
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
